// [shared/gpio_pin_consts.vh]
// Register map, field layout and codes for the remote pin configuration block
`ifndef GPIO_PIN_CONSTS_VH
`define GPIO_PIN_CONSTS_VH

// Register indices; the bus byte address is four times the index
`define P12_SETUP_IDX       8'h1e
`define P3_SETUP_IDX        8'h1f
`define P56_SETUP_IDX       8'h20
`define PORT_CTRL_IDX       8'h30
`define PIN_LEVEL_IDX       8'h31
`define PIN_DRIVE_IDX       8'h32

// Reset values
`define SETUP_RESET         8'h00
`define PORT_CTRL_RESET     8'h00
`define OE_N_RESET          8'hff

// Nibble fields within a pin configuration
`define FLD_LOCAL_VALUE     3
`define FLD_FAR_ON          2
`define FLD_DIRECTION       1
`define FLD_FUNCTION_ON     0

// Direction/enable codes, written as {direction, enable}
`define MODE_FUNC_OUT       2'h0
`define MODE_GPIO_OUT       2'h1
`define MODE_TRISTATE       2'h2
`define MODE_GPIO_IN        2'h3

// Port control register field
`define FLD_SECONDARY_SEL   0

// Bus encodings
`define HTRANS_NONSEQ_BIT   1
`define HRESP_OKAY          1'h0
`define IDX_HI              9
`define IDX_LO              2

`endif

// [rtl/pin_drive_select.v]
// Per-pin decode of a configuration nibble into a drive value and enable
`timescale 1ns/1ps
`include "gpio_pin_consts.vh"

module pin_drive_select (
  // Configuration
  input  wire [3:0] cfg_nibble,
  input  wire       attached,
  // Candidate values
  input  wire       far_value,
  input  wire       func_value,
  // Pad control
  output reg        drive_value,
  output reg        drive_oe_n
);

  always @* begin
    drive_value = 1'h0;
    drive_oe_n  = 1'h1;
    if (!attached) begin
      // A pin on the port not selected stays released
      drive_oe_n = 1'h1;
    end else if (cfg_nibble[`FLD_FAR_ON]) begin
      drive_value = far_value;
      drive_oe_n  = 1'h0;
    end else begin
      case (cfg_nibble[`FLD_DIRECTION:`FLD_FUNCTION_ON])
        `MODE_FUNC_OUT: begin
          drive_value = func_value;
          drive_oe_n  = 1'h0;
        end
        `MODE_GPIO_OUT: begin
          drive_value = cfg_nibble[`FLD_LOCAL_VALUE];
          drive_oe_n  = 1'h0;
        end
        `MODE_TRISTATE: drive_oe_n = 1'h1;
        `MODE_GPIO_IN:  drive_oe_n = 1'h1;
        default:        drive_oe_n = 1'h1;
      endcase
    end
  end

endmodule // pin_drive_select

// [rtl/remote_gpio_pin_config.v]
// Configuration registers and pad control for pins 1, 2, 3, 5, 6 and second port
//
// Function
// - Three setup registers at indices 1Eh, 1Fh, 20h, all resetting to zero.
// - Secondary-port select moves pin 1, 2, 3 settings to the second port.
// - Local value drives pin only with GPIO enabled, output direction, remote off.
// - Remote control on makes pin an output carrying the remote value.
// - Direction/enable: 00 functional out, 10 tri-state, 01 GPIO out, 11 input.
// - Low pin in bits 3:0, high pin 7:4; value, remote, direction, enable.
`timescale 1ns/1ps
`include "gpio_pin_consts.vh"

module remote_gpio_pin_config (
  // Clock, reset and enable
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        ce,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata,
  // Values from the link logic, bits for pins 1, 2, 3, 5, 6
  input  wire [4:0]  far_value,
  input  wire [4:0]  func_value,
  // Primary pins 1, 2, 3, 5, 6
  input  wire [4:0]  pin_in,
  output wire [4:0]  pin_out,
  output wire [4:0]  pin_oe_n,
  // Second port pins 1, 2, 3
  input  wire [2:0]  second_port_pin_in,
  output wire [2:0]  second_port_pin_out,
  output wire [2:0]  second_port_pin_oe_n,
  // Levels seen on pins 1, 2, 3, 5, 6 of the selected port
  output wire [4:0]  pin_level
);

  // Configuration registers
  reg  [7:0]  pins_one_two_setup_r;
  reg  [7:0]  pin_three_setup_r;
  reg  [7:0]  pins_five_six_setup_r;
  reg  [7:0]  port_ctrl_r;

  // Bus slave state
  reg         pend_r;
  reg         wr_r;
  reg         mapped_r;
  reg  [7:0]  idx_r;
  reg         hreadyout_r;
  reg  [31:0] hrdata_r;
  reg         hresp_r;
  reg  [31:0] rd_nxt;

  // Pad synchronisers and registered pad drive
  reg  [7:0]  pad_meta_r;
  reg  [7:0]  pad_sync_r;
  reg  [7:0]  pad_out_r;
  reg  [7:0]  pad_oe_n_r;
  reg  [4:0]  level_r;
  reg  [4:0]  level_nxt;

  // Slot view: 0..2 primary pins 1-3, 3..4 pins 5-6, 5..7 second port 1-3
  wire        secondary_port_select;
  wire [3:0]  nib_one;
  wire [3:0]  nib_two;
  wire [3:0]  nib_three;
  wire [3:0]  nib_five;
  wire [3:0]  nib_six;
  wire [31:0] slot_cfg;
  wire [7:0]  slot_attached;
  wire [7:0]  slot_far;
  wire [7:0]  slot_func;
  wire [7:0]  drv_value;
  wire [7:0]  drv_oe_n;
  wire [7:0]  pad_in;

  wire        addr_take;
  wire        addr_hi_zero;
  wire [7:0]  addr_idx;
  wire        addr_mapped;

  assign secondary_port_select = port_ctrl_r[`FLD_SECONDARY_SEL];

  // Nibble split of each setup register
  assign nib_one   = pins_one_two_setup_r[3:0];
  assign nib_two   = pins_one_two_setup_r[7:4];
  assign nib_three = pin_three_setup_r[3:0];
  assign nib_five  = pins_five_six_setup_r[3:0];
  assign nib_six   = pins_five_six_setup_r[7:4];

  // Pins 1-3 settings feed both ports; only one port is attached at a time
  assign slot_cfg = {nib_three, nib_two, nib_one,
                     nib_six, nib_five,
                     nib_three, nib_two, nib_one};
  assign slot_attached = {{3{secondary_port_select}}, 2'h3,
                          {3{~secondary_port_select}}};
  assign slot_far  = {far_value[2:0], far_value};
  assign slot_func = {func_value[2:0], func_value};

  assign pad_in = {second_port_pin_in, pin_in};

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_slot
      pin_drive_select u_sel (
        .cfg_nibble  (slot_cfg[4*g+3:4*g]),
        .attached    (slot_attached[g]),
        .far_value   (slot_far[g]),
        .func_value  (slot_func[g]),
        .drive_value (drv_value[g]),
        .drive_oe_n  (drv_oe_n[g])
      );
    end
  endgenerate

  // Pads are registered so the pin sees no decode glitches
  always @(posedge ref_clk) begin
    if (rst) begin
      pad_out_r  <= 8'h00;
      pad_oe_n_r <= `OE_N_RESET;
    end else if (ce) begin
      pad_out_r  <= drv_value;
      pad_oe_n_r <= drv_oe_n;
    end
  end

  // Pins come from outside the clock domain
  always @(posedge ref_clk) begin
    if (rst) begin
      pad_meta_r <= 8'h00;
      pad_sync_r <= 8'h00;
    end else if (ce) begin
      pad_meta_r <= pad_in;
      pad_sync_r <= pad_meta_r;
    end
  end

  // Logical pin level follows the port that owns pins 1-3
  always @* begin
    level_nxt[4:3] = pad_sync_r[4:3];
    if (secondary_port_select) begin
      level_nxt[2:0] = pad_sync_r[7:5];
    end else begin
      level_nxt[2:0] = pad_sync_r[2:0];
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      level_r <= 5'h00;
    end else if (ce) begin
      level_r <= level_nxt;
    end
  end

  // Address phase decode
  assign addr_take    = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];
  assign addr_hi_zero = (haddr[31:`IDX_HI+1] == 22'h000000) &&
                        (haddr[`IDX_LO-1:0] == 2'h0);
  assign addr_idx     = haddr[`IDX_HI:`IDX_LO];
  assign addr_mapped  = addr_hi_zero &&
                        ((addr_idx == `P12_SETUP_IDX) ||
                         (addr_idx == `P3_SETUP_IDX)  ||
                         (addr_idx == `P56_SETUP_IDX) ||
                         (addr_idx == `PORT_CTRL_IDX) ||
                         (addr_idx == `PIN_LEVEL_IDX) ||
                         (addr_idx == `PIN_DRIVE_IDX));

  // One wait state: the data phase is served on the edge after the address
  always @(posedge ref_clk) begin
    if (rst) begin
      pend_r      <= 1'h0;
      wr_r        <= 1'h0;
      mapped_r    <= 1'h0;
      idx_r       <= 8'h00;
      hreadyout_r <= 1'h1;
    end else if (ce) begin
      if (pend_r) begin
        pend_r      <= 1'h0;
        hreadyout_r <= 1'h1;
      end else if (addr_take) begin
        pend_r      <= 1'h1;
        wr_r        <= hwrite;
        mapped_r    <= addr_mapped;
        idx_r       <= addr_idx;
        hreadyout_r <= 1'h0;
      end
    end
  end

  // Register writes; only the low byte lane carries data
  always @(posedge ref_clk) begin
    if (rst) begin
      pins_one_two_setup_r  <= `SETUP_RESET;
      pin_three_setup_r     <= `SETUP_RESET;
      pins_five_six_setup_r <= `SETUP_RESET;
      port_ctrl_r           <= `PORT_CTRL_RESET;
    end else if (ce && pend_r && wr_r && mapped_r) begin
      case (idx_r)
        `P12_SETUP_IDX: pins_one_two_setup_r  <= hwdata[7:0];
        `P3_SETUP_IDX:  pin_three_setup_r     <= hwdata[7:0];
        `P56_SETUP_IDX: pins_five_six_setup_r <= hwdata[7:0];
        `PORT_CTRL_IDX: port_ctrl_r <= {7'h00, hwdata[`FLD_SECONDARY_SEL]};
        default:        port_ctrl_r <= port_ctrl_r;
      endcase
    end
  end

  // Read mux; unmapped reads return zero; writes to read-only or unmapped indices are dropped and leave hrdata unchanged; all answer OKAY
  always @* begin
    rd_nxt = 32'h00000000;
    case (idx_r)
      `P12_SETUP_IDX: rd_nxt[7:0] = pins_one_two_setup_r;
      `P3_SETUP_IDX:  rd_nxt[7:0] = pin_three_setup_r;
      `P56_SETUP_IDX: rd_nxt[7:0] = pins_five_six_setup_r;
      `PORT_CTRL_IDX: rd_nxt[7:0] = port_ctrl_r;
      `PIN_LEVEL_IDX: rd_nxt[7:0] = pad_sync_r;
      `PIN_DRIVE_IDX: rd_nxt[15:0] = {~pad_oe_n_r, pad_out_r};
      default:        rd_nxt = 32'h00000000;
    endcase
    if (!mapped_r) begin
      rd_nxt = 32'h00000000;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      hrdata_r <= 32'h00000000;
    end else if (ce && pend_r && !wr_r) begin
      hrdata_r <= rd_nxt;
    end
  end

  // Registered so every bus output leaves a flop; no error response exists
  always @(posedge ref_clk) begin
    hresp_r <= `HRESP_OKAY;
  end

  assign hreadyout = hreadyout_r;
  assign hresp     = hresp_r;
  assign hrdata    = hrdata_r;

  assign pin_out              = pad_out_r[4:0];
  assign pin_oe_n             = pad_oe_n_r[4:0];
  assign second_port_pin_out  = pad_out_r[7:5];
  assign second_port_pin_oe_n = pad_oe_n_r[7:5];
  assign pin_level            = level_r;

endmodule // remote_gpio_pin_config

// [sim/remote_gpio_pin_config_sva.sv]
// Bus and pad-drive assertions for the remote pin configuration block
`timescale 1ns/1ps
module remote_gpio_pin_config_sva (
  // Clock and reset
  input wire        ref_clk,
  input wire        rst,
  // Register bus
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire [31:0] hrdata,
  // Link values and pads
  input wire [4:0]  far_value,
  input wire [4:0]  func_value,
  input wire [4:0]  pin_out,
  input wire [4:0]  pin_oe_n,
  input wire [2:0]  second_port_pin_out,
  input wire [2:0]  second_port_pin_oe_n
);
  reg  [7:0]  s12_r, s3_r, s56_r, a_r, rd;
  reg         sel_r, w_r, p_r;
  reg  [4:0]  eo, ev;
  wire [19:0] nib = {s56_r, s3_r[3:0], s12_r};
  wire [4:0]  po  = eo | {2'h0, {3{sel_r}}};
  wire [2:0]  so  = eo[2:0] | {3{!sel_r}};
  wire [2:0]  sv  = ev[2:0];

  // Shadow copy of the setup registers, tracked from bus traffic alone
  always @(posedge ref_clk) begin
    if (rst) begin
      {s12_r, s3_r, s56_r, sel_r, p_r} <= 26'h0;
    end else begin
      p_r <= hsel && hready && htrans[1];
      a_r <= haddr[9:2];
      w_r <= hwrite;
      if (p_r && w_r) begin
        case (a_r)
          8'h1e: s12_r <= hwdata[7:0];
          8'h1f: s3_r <= hwdata[7:0];
          8'h20: s56_r <= hwdata[7:0];
          8'h30: sel_r <= hwdata[0];
          default: ;
        endcase
      end
    end
  end

  // Remote control wins over direction/enable; direction high releases the pad
  always @* begin
    for (int i = 0; i < 5; i++) begin
      eo[i] = !nib[4*i+2] && nib[4*i+1];
      ev[i] = nib[4*i+2] ? far_value[i] : (nib[4*i] ? nib[4*i+3] : func_value[i]);
    end
    case (a_r)
      8'h1e: rd = s12_r;
      8'h1f: rd = s3_r;
      8'h20: rd = s56_r;
      8'h30: rd = {7'h0, sel_r};
      default: rd = 8'h00;
    endcase
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_bus_wait: assert property (hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout)
    else $error("bus wait state not exactly one cycle");
  chk_reset_pads: assert property ($past(rst) |-> &pin_oe_n && &second_port_pin_oe_n)
    else $error("pads not released right after reset");
  chk_primary_oe: assert property (!$past(rst) |-> pin_oe_n == $past(po))
    else $error("primary pad enable wrong for its setup");
  chk_primary_val: assert property (!$past(rst) |-> (pin_out | pin_oe_n) == ($past(ev) | pin_oe_n))
    else $error("primary pad value wrong for its setup");
  chk_second_oe: assert property (!$past(rst) |-> second_port_pin_oe_n == $past(so))
    else $error("second port pad enable wrong");
  chk_second_val: assert property (!$past(rst) |->
    (second_port_pin_out | second_port_pin_oe_n) == ($past(sv) | second_port_pin_oe_n))
    else $error("second port pad value wrong");
  chk_read_back: assert property ($past(p_r) && !$past(w_r) && $past(a_r) != 8'h31 &&
    $past(a_r) != 8'h32 |-> hrdata == {24'h0, $past(rd)})
    else $error("read data differs from written setup");
  chk_okay_resp: assert property (hsel && hready |-> hresp == 1'b0)
    else $error("bus response not okay");
endmodule // remote_gpio_pin_config_sva

// [sim/far_serializer_model.sv]
// Remote serializer stand-in that forwards remote pin states
`timescale 1ns/1ps
module far_serializer_model (
  // Clock
  input  wire       ref_clk,
  // Remote pin states to send
  input  wire [4:0] send_bits,
  // Values delivered to the deserializer
  output reg  [4:0] far_value = 5'h00
);
  // One cycle of link delay, the least the real forward channel adds
  always @(posedge ref_clk) begin
    far_value <= send_bits;
  end
endmodule // far_serializer_model

// [sim/remote_gpio_pin_config_tb_top.sv]
// Self-checking bench for the remote pin configuration block
`timescale 1ns/1ps
module remote_gpio_pin_config_tb_top;
  logic        ref_clk = 0, rst = 1, hsel = 0, hwrite = 0, sel;
  logic [31:0] haddr = 0, hwdata = 0, q;
  logic [1:0]  htrans = 0;
  logic [4:0]  send = 0, func = 0, f, u, eoe, eout;
  logic [7:0]  c12, c3, c56;
  logic [2:0]  esoe, esout;
  wire         hreadyout, hresp;
  wire  [31:0] hrdata;
  wire  [4:0]  far, pin_out, pin_oe_n, pin_level;
  wire  [2:0]  sp_out, sp_oe_n;
  int          n_errors = 0, n_checks = 0, cyc = 0;
  // Setups, select, far, func, then expected oe_n, out, second oe_n, second out
  logic [50:0] rows [4] = '{
    {8'h00, 8'h00, 8'h00, 1'h0, 5'h00, 5'h15, 5'h00, 5'h15, 3'h7, 3'h0},
    {8'h29, 8'hf3, 8'hd4, 1'h0, 5'h18, 5'h00, 5'h06, 5'h19, 3'h7, 3'h0},
    {8'h29, 8'hf3, 8'hd4, 1'h1, 5'h08, 5'h00, 5'h07, 5'h08, 3'h6, 3'h1},
    {8'h71, 8'h00, 8'h80, 1'h0, 5'h02, 5'h0b, 5'h00, 5'h0a, 3'h7, 3'h0}};

  remote_gpio_pin_config dut (.ref_clk, .rst, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .far_value(far),
    .func_value(func), .pin_in(5'h0a), .pin_out, .pin_oe_n, .second_port_pin_in(3'h5),
    .second_port_pin_out(sp_out), .second_port_pin_oe_n(sp_oe_n), .pin_level);
  far_serializer_model far_side (.ref_clk, .send_bits(send), .far_value(far));

  initial forever #4 ref_clk = ~ref_clk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic xfer(input logic [7:0] idx, input logic w, input logic [7:0] d);
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'h1;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      summarize;
    end
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    chk("pads in reset", {sp_oe_n, pin_oe_n}, 8'hff);
    chk("level in reset", pin_level, 0);
    rst <= 0;
    repeat (2) @(posedge ref_clk);
    chk("pads after reset", {sp_oe_n, pin_oe_n}, 8'he0);
    for (int k = 0; k < 3; k++) begin
      xfer(8'h1e + k[7:0], 0, 8'h00);
      chk("setup reset value", q, 0);
    end
    for (int r = 0; r < 4; r++) begin
      {c12, c3, c56, sel, f, u, eoe, eout, esoe, esout} = rows[r];
      send <= f;
      func <= u;
      xfer(8'h30, 1, {7'h0, sel});
      xfer(8'h1e, 1, c12);
      xfer(8'h1f, 1, c3);
      xfer(8'h20, 1, c56);
      repeat (3) @(posedge ref_clk);
      chk("primary oe_n", pin_oe_n, eoe);
      chk("primary out", pin_out | pin_oe_n, eout | eoe);
      chk("second oe_n", sp_oe_n, esoe);
      chk("second out", sp_out | sp_oe_n, esout | esoe);
      chk("pin level", pin_level, sel ? 5'h0d : 5'h0a);
      xfer(8'h32, 0, 8'h00);
      chk("drive readback", q, {16'h0, ~{esoe, eoe}, esout, eout});
      xfer(8'h1f, 0, 8'h00);
      chk("pin 3 setup", q, c3);
    end
    xfer(8'h31, 0, 8'h00);
    chk("level readback", q, 32'h000000aa);
    xfer(8'h1d, 1, 8'hff);
    xfer(8'h1d, 0, 8'h00);
    chk("unmapped read", q, 0);
    rst <= 1;
    repeat (4) @(posedge ref_clk);
    rst <= 0;
    repeat (2) @(posedge ref_clk);
    xfer(8'h1e, 0, 8'h00);
    chk("setup after reset", q, 0);
    summarize;
  end
endmodule // remote_gpio_pin_config_tb_top

bind remote_gpio_pin_config remote_gpio_pin_config_sva sva (.ref_clk, .rst, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .far_value, .func_value,
  .pin_out, .pin_oe_n, .second_port_pin_out, .second_port_pin_oe_n);
